/* File: cmbx_core_model.sv */
// stand-in for the protocol core: timer, received frames, send handshake
// assumes one clock shared with the mailbox block, standard ids only
module cmbx_core_model (
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic        TX_REQ,
   input  wire logic        stall,
   output logic      [15:0] TIMER_VALUE,
   output logic             RX_SOF,
   output logic             RX_DONE,
   output logic      [28:0] RX_ID,
   output logic             RX_IDE,
   output logic             RX_RTR,
   output logic      [3:0]  RX_DLC,
   output logic             TX_GRANT,
   output logic             TX_DONE,
   output logic      [15:0] sof_time,
   output logic      [15:0] eof_time
);
   // free-running timer on the shared clock
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) TIMER_VALUE <= 16'h0000;
      else TIMER_VALUE <= TIMER_VALUE + 16'h0001;
   end
   // hand a held request to the wire; stall models a busy bus
   initial begin
      {TX_GRANT, TX_DONE, RX_SOF, RX_DONE} = 4'h0;
      {RX_ID, RX_IDE, RX_RTR, RX_DLC} = '0;
      forever begin
         @(posedge CLOCK);
         if (TX_REQ === 1'b1 && stall === 1'b0) begin
            TX_GRANT <= 1'b1;
            @(posedge CLOCK);
            TX_GRANT <= 1'b0;
            repeat (6) @(posedge CLOCK);
            TX_DONE <= 1'b1;
            @(posedge CLOCK);
            TX_DONE <= 1'b0;
            repeat (2) @(posedge CLOCK);
         end
      end
   end
   // one frame: start pulse, then fields with the end pulse
   // fields turn to garbage afterwards so stale values never match
   task automatic frame(input logic [28:0] id, input logic rtr,
                        input logic [3:0] dlc);
      @(posedge CLOCK);
      RX_SOF <= 1'b1;
      sof_time <= TIMER_VALUE + 16'h0001;
      @(posedge CLOCK);
      RX_SOF <= 1'b0;
      repeat (4) @(posedge CLOCK);
      {RX_ID, RX_RTR, RX_DLC} <= {id, rtr, dlc};
      RX_DONE <= 1'b1;
      eof_time <= TIMER_VALUE + 16'h0001;
      @(posedge CLOCK);
      RX_DONE <= 1'b0;
      {RX_ID, RX_RTR, RX_DLC} <= ~{id, rtr, dlc};
   endtask
endmodule

/* File: cmbx_mailbox_ctrl.sv */
// mailbox configuration, acceptance, abort and status for eight mailboxes
// assumes an APB master on CLOCK and a protocol core giving frame events
//
// Implementation choices: the register addresses and register access over APB.
module cmbx_mailbox_ctrl
   import cmbx_pkg::*;
#(
   parameter int NMB = 8
)(
   input  wire logic         CLOCK,
   input  wire logic         RESETN,
   input  wire logic         PSEL,
   input  wire logic         PENABLE,
   input  wire logic         PWRITE,
   input  wire logic [11:0]  PADDR,
   input  wire logic [31:0]  PWDATA,
   output logic      [31:0]  PRDATA,
   output logic              PREADY,
   output logic              PSLVERR,
   input  wire logic [15:0]  TIMER_VALUE,
   input  wire logic         RX_DONE,
   input  wire logic         RX_SOF,
   input  wire logic [28:0]  RX_ID,
   input  wire logic         RX_IDE,
   input  wire logic         RX_RTR,
   input  wire logic [3:0]   RX_DLC,
   input  wire logic         TX_GRANT,
   input  wire logic         TX_DONE,
   output logic              TX_REQ,
   output logic      [2:0]   TX_MBX,
   output logic              TX_RTR,
   output logic      [7:0]   DATA_UNLOCKED
);
`include "cmbx_regs.svh"
   initial begin
      if (NMB != 8) $error("cmbx: only eight mailboxes supported");
   end

   typedef struct packed {
      logic [NMB-1:0][31:0] mode;
      logic [NMB-1:0][29:0] mask;
      logic [NMB-1:0][29:0] ident;
      logic [NMB-1:0][3:0]  dlc;
      logic [NMB-1:0]       rdy, abt, message_ignored_flag, rtr, pend, skip_rtr, busy;
      logic [NMB-1:0][15:0] stamp;
      logic [NMB-1:0][15:0] sof_time;
      logic [1:0]           gcfg;
      logic [31:0]          rdata;
      logic                 ready, tx_req, tx_rtr;
      logic [2:0]           tx_mbx;
   } cmbx_state_s;

   cmbx_state_s st_ff, nxt_st;

   // family id: pack masked bits lsb-first
   function automatic logic [28:0] fam(input logic [28:0] id,
                                       input logic [28:0] m);
      logic [28:0] r;
      int k;
      r = '0;
      k = 0;
      for (int i = 0; i < 29; i++) begin
         if (m[i]) begin
            r[k[4:0]] = id[i];
            k = k + 1;
         end
      end
      return r;
   endfunction

   // identifier as read: extended bits zero in standard format
   function automatic logic [29:0] idv(input logic [29:0] v);
      return v[29] ? v : {v[29:18], 18'h0};
   endfunction

   logic [NMB-1:0] match;
   logic           acc;
   logic [2:0]     rmb, wsel;
   logic [3:0]     best_pri;
   logic           found;

   // acceptance compare through the mask
   always_comb begin
      for (int i = 0; i < NMB; i++) begin
         if (st_ff.mask[i][29])
            match[i] = RX_IDE == st_ff.ident[i][29] &&
               ((RX_ID ^ st_ff.ident[i][28:0]) & st_ff.mask[i][28:0]) == '0;
         else
            match[i] = !RX_IDE && ((RX_ID[28:18] ^ st_ff.ident[i][28:18])
               & st_ff.mask[i][28:18]) == '0;
      end
   end

   assign acc = PSEL && PENABLE;
   assign rmb = PADDR[7:5];

   // next state: bus, frame events and transmit arbitration
   always_comb begin
      logic rx_taken;
      logic [2:0] ot;
      nxt_st = st_ff;
      rx_taken = 1'b0;
      ot = 3'h0;
      found = 1'b0;
      best_pri = 4'h0;
      wsel = 3'h0;
      nxt_st.ready = PSEL && !st_ff.ready;
      // register writes
      if (acc && st_ff.ready && PWRITE) begin
         if (PADDR == `CMBX_ABORT_OFS || PADDR == `CMBX_TRANSFER_OFS) begin
            for (int i = 0; i < NMB; i++) begin
               if (PWDATA[i]) begin
                  // abort on a receive box must leave its flags alone
                  if (PADDR == `CMBX_TRANSFER_OFS) begin
                     nxt_st.rdy[i] = 1'b0;
                     nxt_st.abt[i] = 1'b0;
                     nxt_st.pend[i] = 1'b1;
                  end
                  else if (!st_ff.busy[i] &&
                     st_ff.mode[i][26:24] >= 3'h3) begin
                     nxt_st.pend[i] = 1'b0;
                     nxt_st.abt[i] = 1'b1;
                     nxt_st.skip_rtr[i] = st_ff.mode[i][26:24] == 3'h5;
                  end
               end
            end
         end
         else if (PADDR == `CMBX_GLOBAL_OFS)
            nxt_st.gcfg = PWDATA[1:0];
         else if (PADDR[11:8] == 4'h2) begin
            case (PADDR[4:2])
               `CMBX_MODE_OFS: begin
                  nxt_st.mode[rmb] = PWDATA & 32'h070F_FFFF;
                  ot = PWDATA[26:24];
                  nxt_st.rdy[rmb] = ot == 3'h3 || ot == 3'h5;
                  nxt_st.rtr[rmb] = ot == 3'h4;
                  nxt_st.pend[rmb] = 1'b0;
               end
               `CMBX_MASK_OFS: nxt_st.mask[rmb] = PWDATA[29:0];
               `CMBX_ID_OFS:   nxt_st.ident[rmb] = idv(PWDATA[29:0]);
               `CMBX_CONTROL_OFS: begin
                  if (PWDATA[`CMBX_TRANSFER_COMMAND_BIT_BIT] || PWDATA[`CMBX_ABORT_COMMAND_BIT_BIT]) begin
                     nxt_st.rdy[rmb] = 1'b0;
                     nxt_st.abt[rmb] = 1'b0;
                     nxt_st.pend[rmb] = PWDATA[`CMBX_TRANSFER_COMMAND_BIT_BIT];
                  end
                  if (PWDATA[`CMBX_ABORT_COMMAND_BIT_BIT] && !st_ff.busy[rmb] &&
                      st_ff.mode[rmb][26:24] >= 3'h3) begin
                     nxt_st.pend[rmb] = 1'b0;
                     nxt_st.abt[rmb] = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
      // reads: data formed at setup so it stands beside PREADY
      nxt_st.rdata = 32'h0;
      if (PSEL && !PENABLE && !PWRITE) begin
         if (PADDR == `CMBX_GLOBAL_OFS)
            nxt_st.rdata = {30'h0, st_ff.gcfg};
         else if (PADDR[11:8] == 4'h2) begin
            case (PADDR[4:2])
               `CMBX_MODE_OFS:
                  nxt_st.rdata = st_ff.gcfg[0] ? st_ff.mode[rmb]
                     : {st_ff.mode[rmb][31:16], 16'h0};
               `CMBX_MASK_OFS: nxt_st.rdata = {2'b0, st_ff.mask[rmb]};
               `CMBX_ID_OFS:   nxt_st.rdata = {2'b0, idv(st_ff.ident[rmb])};
               // family packs the id bits that the mask leaves open
               `CMBX_FAMILY_OFS:
                  nxt_st.rdata = {3'b0, fam(st_ff.ident[rmb][28:0],
                                            ~st_ff.mask[rmb][28:0])};
               `CMBX_STATUS_OFS:
                  nxt_st.rdata = {7'h0, st_ff.message_ignored_flag[rmb], st_ff.rdy[rmb],
                     st_ff.abt[rmb], 1'b0, st_ff.rtr[rmb], st_ff.dlc[rmb],
                     st_ff.gcfg[0] ? 16'h0 : st_ff.stamp[rmb]};
               default: nxt_st.rdata = 32'h0;
            endcase
         end
      end
      // ignored flag clears at the taken edge; a frame below wins
      if (acc && st_ff.ready && !PWRITE && PADDR[11:8] == 4'h2 &&
          PADDR[4:2] == `CMBX_STATUS_OFS)
         nxt_st.message_ignored_flag[rmb] = 1'b0;
      // frame start capture
      if (RX_SOF) begin
         for (int i = 0; i < NMB; i++) nxt_st.sof_time[i] = TIMER_VALUE;
      end
      // received frame: lowest matching index takes it
      if (RX_DONE) begin
         for (int i = 0; i < NMB; i++) begin
            ot = st_ff.mode[i][26:24];
            if (!rx_taken && match[i] && ot != 3'h0 && ot != 3'h3) begin
               if (ot == 3'h5 && RX_RTR) begin
                  rx_taken = 1'b1;
                  if (st_ff.skip_rtr[i]) nxt_st.skip_rtr[i] = 1'b0;
                  else if (!st_ff.pend[i]) nxt_st.message_ignored_flag[i] = 1'b1;
                  else nxt_st.busy[i] = 1'b1;
               end
               else if (ot != 3'h5 && st_ff.pend[i] &&
                        !(ot == 3'h4 && !st_ff.busy[i])) begin
                  rx_taken = 1'b1;
                  if (st_ff.rdy[i] && ot != 3'h2) nxt_st.message_ignored_flag[i] = 1'b1;
                  else begin
                     if (st_ff.rdy[i]) nxt_st.message_ignored_flag[i] = 1'b1;
                     nxt_st.rdy[i] = 1'b1;
                     nxt_st.dlc[i] = RX_DLC;
                     nxt_st.rtr[i] = RX_RTR;
                     if (!st_ff.gcfg[0])
                        nxt_st.stamp[i] = st_ff.gcfg[1] ? TIMER_VALUE
                           : st_ff.sof_time[i];
                     if (ot == 3'h4) begin
                        nxt_st.pend[i] = 1'b0;
                        nxt_st.busy[i] = 1'b0;
                     end
                  end
               end
            end
         end
      end
      // transmit arbitration over pending transmitters
      for (int i = 0; i < NMB; i++) begin
         ot = st_ff.mode[i][26:24];
         if (st_ff.pend[i] && (ot == 3'h3 || (ot == 3'h4 && !st_ff.busy[i])
             || (ot == 3'h5 && st_ff.busy[i])) &&
             (!st_ff.gcfg[0] || TIMER_VALUE >= st_ff.mode[i][15:0]) &&
             (!found || {1'b0, st_ff.mode[i][19:16]} > {1'b0, best_pri})) begin
            found = 1'b1;
            best_pri = st_ff.mode[i][19:16];
            wsel = 3'(i);
         end
      end
      if (!st_ff.tx_req && found) begin
         nxt_st.tx_req = 1'b1;
         nxt_st.tx_mbx = wsel;
         nxt_st.tx_rtr = st_ff.mode[wsel][26:24] == 3'h4;
      end
      if (st_ff.tx_req && TX_GRANT) nxt_st.busy[st_ff.tx_mbx] = 1'b1;
      if (st_ff.tx_req && !st_ff.pend[st_ff.tx_mbx]) nxt_st.tx_req = 1'b0;
      if (st_ff.tx_req && TX_DONE) begin
         nxt_st.tx_req = 1'b0;
         nxt_st.busy[st_ff.tx_mbx] = st_ff.tx_rtr; // consumer awaits reply
         if (!st_ff.tx_rtr) begin
            nxt_st.pend[st_ff.tx_mbx] = 1'b0;
            nxt_st.rdy[st_ff.tx_mbx] = 1'b1;
            if (!st_ff.gcfg[0])
               nxt_st.stamp[st_ff.tx_mbx] = st_ff.gcfg[1] ? TIMER_VALUE
                  : st_ff.sof_time[st_ff.tx_mbx];
         end
      end
   end

   // one register bank for all state
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   // outputs other than PSLVERR come straight from the state flops; PSLVERR is tied low
   assign PRDATA = st_ff.rdata;
   assign PREADY = st_ff.ready;
   assign PSLVERR = 1'b0;
   assign TX_REQ = st_ff.tx_req;
   assign TX_MBX = st_ff.tx_mbx;
   assign TX_RTR = st_ff.tx_rtr;
   assign DATA_UNLOCKED = st_ff.rdy;

   property p_abort_sets;
      @(posedge CLOCK) disable iff (!RESETN)
      (acc && PWRITE && st_ff.ready && PADDR == `CMBX_ABORT_OFS && PWDATA[0]
       && !st_ff.busy[0] && st_ff.mode[0][26:24] == 3'h3) |=> st_ff.abt[0];
   endproperty
   a_abort_sets: assert property (p_abort_sets) else $error("abort lost");

   property p_rx_abort_none;
      @(posedge CLOCK) disable iff (!RESETN)
      (acc && PWRITE && st_ff.ready && PADDR == `CMBX_ABORT_OFS &&
       st_ff.mode[0][26:24] == 3'h1) |=> !st_ff.abt[0];
   endproperty
   a_rx_abort_none: assert property (p_rx_abort_none) else $error("rx abort");

   property p_disabled_quiet;
      @(posedge CLOCK) disable iff (!RESETN)
      (st_ff.mode[st_ff.tx_mbx][26:24] == 3'h0 && $rose(st_ff.tx_req)) |-> 1'b0;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("dis tx");

   // no wait state: ready high for a single cycle right after setup
   sequence s_ready_pulse;
      PREADY ##1 !PREADY;
   endsequence

   property p_ready_timing;
      @(posedge CLOCK) disable iff (!RESETN)
      (PSEL && !PENABLE) |=> s_ready_pulse;
   endproperty
   a_ready_timing: assert property (p_ready_timing) else $error("pready");

   property p_tt_wait;
      @(posedge CLOCK) disable iff (!RESETN)
      $rose(st_ff.tx_req) && st_ff.gcfg[0] |->
         $past(TIMER_VALUE) >= st_ff.mode[st_ff.tx_mbx][15:0];
   endproperty
   a_tt_wait: assert property (p_tt_wait) else $error("early tx");

   property p_stamp_hold;
      @(posedge CLOCK) disable iff (!RESETN)
      st_ff.gcfg[0] |=> $stable(st_ff.stamp);
   endproperty
   a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved");

   property p_unlock;
      @(posedge CLOCK) disable iff (!RESETN)
      (acc && PWRITE && st_ff.ready && PADDR[11:8] == 4'h2 &&
       PADDR[4:2] == `CMBX_MODE_OFS && PWDATA[26:24] == 3'h3)
      |=> DATA_UNLOCKED[$past(rmb)];
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock");

   property p_full_discard;
      @(posedge CLOCK) disable iff (!RESETN)
      (RX_DONE && match[0] && st_ff.mode[0][26:24] == 3'h1 && st_ff.rdy[0]
       && st_ff.pend[0]) |=> $stable(st_ff.dlc[0]) && st_ff.message_ignored_flag[0];
   endproperty
   a_full_discard: assert property (p_full_discard) else $error("overrun");
endmodule

/* File: cmbx_pkg.sv */
// types of the mailbox control block
// assumes cmbx_regs.svh holds the numbers
package cmbx_pkg;
   typedef enum logic [2:0] {
      CMBX_DISABLED  = 3'h0,
      CMBX_RECEIVE   = 3'h1,
      CMBX_RX_OVWR   = 3'h2,
      CMBX_TRANSMIT  = 3'h3,
      CMBX_CONSUMER  = 3'h4,
      CMBX_PRODUCER  = 3'h5
   } cmbx_mot_e;
   // per-mailbox transfer state, gray along idle-wait-busy
   typedef enum logic [1:0] {
      CMBX_IDLE = 2'b00,
      CMBX_WAIT = 2'b01,
      CMBX_BUSY = 2'b11
   } cmbx_st_e;
endpackage

/* File: cmbx_regs.svh */
// register offsets, field positions and reset values of the mailbox block
// assumes an APB slave with 32-bit words, one mailbox per 0x20 block
`ifndef CMBX_REGS_SVH
`define CMBX_REGS_SVH
`define CMBX_ABORT_OFS     12'h004
`define CMBX_TRANSFER_OFS  12'h008
`define CMBX_GLOBAL_OFS    12'h00C
`define CMBX_MBX_BASE      12'h200
`define CMBX_MODE_OFS      3'h0
`define CMBX_MASK_OFS      3'h1
`define CMBX_ID_OFS        3'h2
`define CMBX_FAMILY_OFS    3'h3
`define CMBX_STATUS_OFS    3'h4
`define CMBX_CONTROL_OFS   3'h5
`define CMBX_FRAME_OFS     3'h6
`define CMBX_MOT_LSB       24
`define CMBX_PRIOR_LSB     16
`define CMBX_IDE_BIT       29
`define CMBX_STDID_LSB     18
`define CMBX_MMI_BIT       24
`define CMBX_MAILBOX_READY_FLAG_BIT      23
`define CMBX_MAILBOX_ABORT_FLAG_BIT      22
`define CMBX_REMOTE_REQUEST_FLAG_BIT      20
`define CMBX_DLC_LSB       16
`define CMBX_ABORT_COMMAND_BIT_BIT      22
`define CMBX_TRANSFER_COMMAND_BIT_BIT      23
`define CMBX_TTM_BIT       0
`define CMBX_CAPTURE_AT_FRAME_END_BIT      1
`define CMBX_RESET_WORD    32'h0000_0000
`endif

/* File: cmbx_tb.sv */
// self-checking bench for the mailbox control block over APB
// assumes cmbx_core_model plays the protocol core on the far side
`include "cmbx_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb
   import cmbx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_ABT = `CMBX_ABORT_OFS;
   localparam logic [11:0] A_TRN = `CMBX_TRANSFER_OFS;
   localparam logic [11:0] A_GLB = `CMBX_GLOBAL_OFS;
   localparam logic [2:0]  M_MODE = `CMBX_MODE_OFS, M_MASK = `CMBX_MASK_OFS;
   localparam logic [2:0]  M_ID = `CMBX_ID_OFS, M_FAM = `CMBX_FAMILY_OFS;
   localparam logic [2:0]  M_STAT = `CMBX_STATUS_OFS;
   localparam logic [2:0]  M_CTRL = `CMBX_CONTROL_OFS;
   localparam int          RDY = `CMBX_MAILBOX_READY_FLAG_BIT, ABT = `CMBX_MAILBOX_ABORT_FLAG_BIT;
   localparam int          IGN = `CMBX_MMI_BIT;
   logic        CLOCK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic        RX_SOF, RX_DONE, RX_IDE, RX_RTR, stall;
   logic        TX_GRANT, TX_DONE, TX_REQ, TX_RTR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic [28:0] RX_ID;
   logic [3:0]  RX_DLC;
   logic [2:0]  TX_MBX;
   logic [7:0]  DATA_UNLOCKED;
   logic [15:0] TIMER_VALUE, sof_time, eof_time;
   int          failures = 0;
   int          samples_checked = 0;
   cmbx_mailbox_ctrl dut_u (.*);
   cmbx_core_model core_u (.*);
   // clock at 250 MHz
   initial begin
      CLOCK = 1'b0;
      forever #2 CLOCK = ~CLOCK;
   end
   task automatic stop_test();
      if (failures == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic hang(input string nm);
      failures++;
      $display("BAD %s exp %h got %h", nm, 1'b1, 1'b0);
      stop_test();
   endtask
   // one APB transfer; a setup-free gap keeps drives one per time step
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge CLOCK);
      {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, wd};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) hang("pready");
      rd = PRDATA;
      {PSEL, PENABLE} <= 2'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask
   function automatic logic [11:0] mb(input int n, input logic [2:0] o);
      return `CMBX_MBX_BASE + 12'(n * 32) + {7'h00, o, 2'h0};
   endfunction
   function automatic logic [31:0] mode(input logic [2:0] t,
                                        input logic [3:0] p,
                                        input logic [15:0] mk);
      return {5'h00, t, 4'h0, p, mk};
   endfunction
   task automatic req_is(input logic v, input int lim);
      int n;
      n = 0;
      while (TX_REQ !== v && n < lim) begin
         @(posedge CLOCK);
         n++;
      end
      if (TX_REQ !== v) hang("tx_req");
   endtask
   task automatic grant_is(input logic [2:0] m);
      int n;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (TX_GRANT !== 1'b1 && n < 200);
      if (TX_GRANT !== 1'b1) hang("grant");
      `CHK("granted box", m, TX_MBX)
   endtask
   // identifier views, type-write ready values, unmapped place
   task automatic t_regs();
      logic [31:0] r;
      rd(mb(7, M_MODE), r);
      `CHK("mode reset", `CMBX_RESET_WORD, r)
      wr(mb(2, M_MODE), 32'h0);
      wr(mb(2, M_ID), 32'h305A_4321);
      wr(mb(2, M_MASK), 32'h3FF0_F0FF);
      rd(mb(2, M_FAM), r);
      `CHK("family", 32'h0000_00A3, r)
      wr(mb(2, M_ID), 32'h0040_1234);
      rd(mb(2, M_ID), r);
      `CHK("std id", 32'h0040_0000, r)
      wr(mb(2, M_MODE), mode(CMBX_TRANSMIT, 4'h1, 16'h1234));
      rd(mb(2, M_MODE), r);
      `CHK("mark", 16'h0000, r[15:0])
      rd(mb(2, M_STAT), r);
      `CHK("tx ready", 2'h3, {r[RDY], DATA_UNLOCKED[2]})
      wr(mb(2, M_MODE), mode(CMBX_RECEIVE, 4'h0, 16'h0));
      rd(mb(2, M_STAT), r);
      `CHK("rx ready", 2'h0, {r[RDY], DATA_UNLOCKED[2]})
      wr(12'h0F0, 32'hFFFF_FFFF);
      rd(12'h0F0, r);
      `CHK("unmapped", 32'h0, r)
   endtask
   // abort before handoff cancels, after handoff the frame completes
   task automatic t_abort();
      logic [31:0] r;
      stall <= 1'b1;
      wr(mb(0, M_MODE), mode(CMBX_TRANSMIT, 4'h0, 16'h0));
      wr(mb(1, M_MODE), mode(CMBX_RECEIVE, 4'h0, 16'h0));
      wr(A_TRN, 32'h0000_0003);
      req_is(1'b1, 20);
      wr(A_ABT, 32'h0000_0003);
      req_is(1'b0, 20);
      rd(mb(0, M_STAT), r);
      `CHK("tx abort", 1'b1, r[ABT])
      rd(mb(1, M_STAT), r);
      `CHK("rx abort", 1'b0, r[ABT])
      wr(mb(0, M_CTRL), 32'h0000_0001 << `CMBX_TRANSFER_COMMAND_BIT_BIT);
      rd(mb(0, M_STAT), r);
      `CHK("abort clr", 1'b0, r[ABT])
      stall <= 1'b0;
      grant_is(3'h0);
      wr(A_ABT, 32'h0000_0001);
      req_is(1'b0, 40);
      rd(mb(0, M_STAT), r);
      `CHK("late abort", 2'h2, {r[RDY], r[ABT]})
   endtask
   // three senders contend while the bus is busy
   task automatic t_prio();
      stall <= 1'b1;
      wr(mb(3, M_MODE), mode(CMBX_TRANSMIT, 4'h2, 16'h0));
      wr(mb(4, M_MODE), mode(CMBX_TRANSMIT, 4'h5, 16'h0));
      wr(mb(5, M_MODE), mode(CMBX_TRANSMIT, 4'h5, 16'h0));
      wr(A_TRN, 32'h0000_0078);
      repeat (2) @(posedge CLOCK);
      `CHK("locked", 3'h0, DATA_UNLOCKED[5:3])
      stall <= 1'b0;
      grant_is(3'h4);
      grant_is(3'h5);
      grant_is(3'h3);
      req_is(1'b0, 40);
      repeat (20) @(posedge CLOCK);
      `CHK("disabled idle", 1'b0, TX_REQ)
      `CHK("sent", 3'h7, DATA_UNLOCKED[5:3])
   endtask
   // full box keeps the first, overwrite box keeps the last
   task automatic t_rx();
      logic [31:0] r;
      logic [15:0] t;
      wr(mb(0, M_MODE), 32'h0);
      wr(mb(1, M_MODE), 32'h0);
      wr(mb(0, M_ID), 32'h048C_0000);
      wr(mb(1, M_ID), 32'h03C0_0000);
      wr(mb(0, M_MASK), 32'h1FFC_0000);
      wr(mb(1, M_MASK), 32'h1FFC_0000);
      wr(mb(0, M_MODE), mode(CMBX_RECEIVE, 4'h0, 16'h0));
      wr(mb(1, M_MODE), mode(CMBX_RX_OVWR, 4'h0, 16'h0));
      wr(A_GLB, 32'h0);
      wr(A_TRN, 32'h0000_0003);
      core_u.frame(29'h0490_0000, 1'b0, 4'h7);
      core_u.frame(29'h048C_0000, 1'b0, 4'h3);
      t = sof_time;
      core_u.frame(29'h048C_0000, 1'b0, 4'h5);
      rd(mb(0, M_STAT), r);
      `CHK("rx stat", 6'h33, {r[IGN], r[RDY], r[19:16]})
      `CHK("sof stamp", t, r[15:0])
      rd(mb(0, M_STAT), r);
      `CHK("ign clr", 1'b0, r[IGN])
      wr(A_GLB, 32'h0000_0001 << `CMBX_CAPTURE_AT_FRAME_END_BIT);
      core_u.frame(29'h03C0_0000, 1'b0, 4'h2);
      core_u.frame(29'h03C0_0000, 1'b0, 4'h6);
      t = eof_time;
      rd(mb(1, M_STAT), r);
      `CHK("ovwr stat", 6'h36, {r[IGN], r[RDY], r[19:16]})
      `CHK("eof stamp", t, r[15:0])
      wr(A_GLB, 32'h0);
   endtask
   // consumer asks first, producer waits to be asked
   task automatic t_cp();
      wr(mb(2, M_MODE), 32'h0);
      wr(mb(2, M_ID), 32'h0140_0000);
      wr(mb(2, M_MODE), mode(CMBX_CONSUMER, 4'h0, 16'h0));
      wr(mb(6, M_ID), 32'h0154_0000);
      wr(mb(6, M_MASK), 32'h1FFC_0000);
      wr(mb(6, M_MODE), mode(CMBX_PRODUCER, 4'h0, 16'h0));
      wr(A_TRN, 32'h0000_0044);
      req_is(1'b1, 20);
      `CHK("remote req", 4'hA, {TX_RTR, TX_MBX})
      req_is(1'b0, 40);
      repeat (20) @(posedge CLOCK);
      `CHK("producer waits", 1'b0, TX_REQ)
      core_u.frame(29'h0154_0000, 1'b1, 4'h0);
      req_is(1'b1, 20);
      `CHK("answer", 4'h6, {TX_RTR, TX_MBX})
      req_is(1'b0, 40);
   endtask
   // time-triggered send waits for its mark; stamps then read zero
   task automatic t_ttm();
      logic [31:0] r;
      logic [15:0] t;
      wr(A_GLB, 32'h0000_0001 << `CMBX_TTM_BIT);
      t = TIMER_VALUE + 16'h0064;
      wr(mb(4, M_MODE), mode(CMBX_TRANSMIT, 4'h0, t));
      wr(A_TRN, 32'h0000_0010);
      req_is(1'b1, 200);
      t = TIMER_VALUE - t;
      `CHK("at mark", 1'b1, t < 16'h0004)
      req_is(1'b0, 40);
      rd(mb(4, M_STAT), r);
      `CHK("tt stamp", 16'h0000, r[15:0])
   endtask
   // reset for ten cycles, then the scenarios in turn
   initial begin
      {RESETN, PSEL, PENABLE, PWRITE, stall} = 5'h00;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      repeat (10) @(posedge CLOCK);
      RESETN <= 1'b1;
      t_regs();
      t_abort();
      t_prio();
      t_rx();
      t_cp();
      t_ttm();
      stop_test();
   end
endmodule
